// ===== bench/cache_tlb_debug_readout_tb.sv
// self-checking bench for the cache and tlb readout path
module cache_tlb_debug_readout_tb import readout_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // 32KB data cache, so the set field tops out at bit 12
    localparam int S = 13;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    sysreg_req_t req_i = '0;
    logic        req_ready_o;
    sysreg_rsp_t rsp_o;
    ram_req_t    ram_req_o;
    ram_rsp_t    ram_rsp_i = '0;
    int          n_errors = 0;
    int          checks_done = 0;
    logic [64:0] rsp_q[$];
    ram_req_t    ram_q[$];
    logic [64:0] note;
    ram_req_t    ram_note;
    logic [88:0] ram_data = '0;
    logic [63:0] exp_w[3];
    // 64KB twin: set field reaches bit 13
    localparam int S_BIG = 14;
    logic [8:0]  tlb_edge[7] = '{9'h0ff, 9'h100, 9'h10f, 9'h110, 9'h11f, 9'h120, 9'h1ff};
    logic [8:0]  big_q[$];
    ram_req_t    ram_req_big;
    sysreg_rsp_t rsp_big;

    cache_tlb_debug_readout #(
        .LARGE_DCACHE (1'b0)
    ) cache_tlb_debug_readout_i (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .req_i       (req_i),
        .req_ready_o (req_ready_o),
        .rsp_o       (rsp_o),
        .ram_req_o   (ram_req_o),
        .ram_rsp_i   (ram_rsp_i)
    );

    // same requests and ram answers: only the set field may differ
    cache_tlb_debug_readout #(
        .LARGE_DCACHE (1'b1)
    ) cache_tlb_debug_readout_big_i (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .req_i       (req_i),
        .req_ready_o (),
        .rsp_o       (rsp_big),
        .ram_req_o   (ram_req_big),
        .ram_rsp_i   (ram_rsp_i)
    );

    always #2.5 clock_i = ~clock_i;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // one request at a time: waits until the previous answer has been compared, then drives the request for one cycle
    task automatic send(input logic wr, input logic [1:0] op0, input logic [2:0] op1,
                        input logic [3:0] crm, input logic [2:0] op2, input logic [1:0] el,
                        input logic [63:0] wd, input logic undef, input logic [63:0] rd);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 || rsp_q.size() != 0) begin
            n++;
            if (n > 200) begin
                n_errors++;
                report_and_stop();
            end
            @(negedge clock_i);
        end
        rsp_q.push_back({undef, rd});
        req_i.valid = 1'b1;
        req_i.write = wr;
        req_i.enc = '{op0, op1, 4'hf, crm, op2};
        req_i.el = el;
        req_i.wdata = wd;
        @(negedge clock_i);
        req_i.valid = 1'b0;
    endtask : send

    task automatic op(input ram_target_t t, input logic [31:0] wd);
        ram_req_t    n;
        logic [88:0] d;
        int          k;
        n = '0;
        d = 89'({$urandom, $urandom, $urandom});
        ram_data = d;
        exp_w = '{64'h0, 64'h0, 64'h0};
        n.target = t;
        n.way = wd[31:30];
        n.index = 9'(wd[S-1:6]);
        case (t)
            TGT_DC_TAG: begin
                exp_w[0] = 64'({d[3], d[4], d[6:5], d[7]});
                exp_w[1] = 64'({d[1:0], d[2], 29'h0});
            end
            TGT_DC_DATA, TGT_IC_TAG: begin
                n.offset = {1'b0, wd[5:3]};
                exp_w[0] = 64'(d[31:0]);
                exp_w[1] = 64'(d[63:32]);
            end
            TGT_IC_DATA: begin
                n.offset = wd[5:2];
                exp_w[0] = 64'(d[19:0]);
                exp_w[1] = 64'(d[39:20]);
            end
            default: begin
                n.index = wd[8:0];
                n.part = !wd[8] ? PART_MAIN : (wd[4] ? PART_IPA : PART_WALK);
                if (wd[8:0] <= 9'h11f) begin
                    exp_w = '{64'(d[31:0]), 64'(d[63:32]), 64'(d[88:64])};
                end
            end
        endcase
        if (n.index <= 9'h11f) begin
            ram_q.push_back(n);
            big_q.push_back(t inside {TGT_TLB_TAG, TGT_TLB_DATA} ?
                            wd[8:0] : 9'(wd[S_BIG-1:6]));
        end
        send(1'b1, 2'h1, 3'h6, t[0] ? 4'h4 : 4'h2, 3'(int'(t) / 2), 2'h3,
             {$urandom, wd}, 1'b0, 64'h0);
        for (k = 0; k < 6; k++) begin
            send(1'b0, 2'h3, 3'h6, 4'h0, 3'(k % 3), 2'h3, 64'($urandom), 1'b0,
                 exp_w[k % 3]);
        end
    endtask : op

    // answer watcher: oldest note against each answer pulse
    always @(posedge clock_i) begin
        if (rsp_o.valid === 1'b1) begin
            if (rsp_q.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                note = rsp_q.pop_front();
                check(64'(rsp_o.undef), 64'(note[64]));
                check(rsp_o.rdata, note[63:0]);
                check(64'({rsp_big.valid, rsp_big.undef}), 64'({1'b1, note[64]}));
                check(rsp_big.rdata, note[63:0]);
            end
        end
    end

    // ram stand-in: checks the selection, then answers after a random stall
    initial begin
        forever begin
            @(posedge clock_i);
            if (ram_req_o.valid === 1'b1) begin
                if (ram_q.size() == 0) begin
                    check(64'h1, 64'h0);
                end else begin
                    ram_note = ram_q.pop_front();
                    check(64'({ram_req_o.target, ram_req_o.way, ram_req_o.index}),
                          64'({ram_note.target, ram_note.way, ram_note.index}));
                    check(64'({ram_req_big.valid, ram_req_big.index}),
                          64'({1'b1, big_q.pop_front()}));
                    if (ram_note.target inside {TGT_DC_DATA, TGT_IC_DATA}) begin
                        check(64'(ram_req_o.offset), 64'(ram_note.offset));
                    end
                    if (ram_note.target inside {TGT_TLB_TAG, TGT_TLB_DATA}) begin
                        check(64'(ram_req_o.part), 64'(ram_note.part));
                    end
                end
                repeat ($urandom_range(6)) @(negedge clock_i);
                @(negedge clock_i);
                ram_rsp_i = {1'b1, ram_data};
                @(negedge clock_i);
                ram_rsp_i.valid = 1'b0;
            end
        end
    end

    // hang guard
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        int   i;
        void'($urandom(3));
        repeat (10) @(negedge clock_i);
        check(64'(req_ready_o), 64'h0);
        rst_b_i = 1'b1;
        for (i = 0; i < 30; i++) begin
            op(ram_target_t'(i % 6), $urandom);
        end
        // tlb index edges: main, walk, ipa and past the end
        for (i = 0; i < 7; i++) begin
            op(ram_target_t'(4 + i % 2), {2'(i), 21'h1f_ffff, tlb_edge[i]});
        end
        op(TGT_DC_DATA, $urandom);
        // refused accesses: wrong level, bad encodings, wrong direction
        for (i = 0; i < 3; i++) begin
            send(1'b0, 2'h3, 3'h6, 4'h0, 3'h0, 2'(i), 64'h0, 1'b1, 64'h0);
            send(1'b1, 2'h1, 3'h6, 4'h2, 3'(i), 2'(i), 64'h0, 1'b1, 64'h0);
        end
        send(1'b0, 2'h3, 3'h5, 4'h0, 3'h0, 2'h3, 64'h0, 1'b1, 64'h0);
        send(1'b0, 2'h3, 3'h6, 4'h0, 3'h3, 2'h3, 64'h0, 1'b1, 64'h0);
        send(1'b1, 2'h3, 3'h6, 4'h0, 3'h0, 2'h3, 64'h0, 1'b1, 64'h0);
        send(1'b0, 2'h1, 3'h6, 4'h2, 3'h0, 2'h3, 64'h0, 1'b1, 64'h0);
        send(1'b0, 2'h1, 3'h6, 4'h4, 3'h1, 2'h3, 64'h0, 1'b1, 64'h0);
        // refused accesses leave the results alone
        for (i = 0; i < 3; i++) begin
            send(1'b0, 2'h3, 3'h6, 4'h0, 3'(i), 2'h3, 64'h0, 1'b0, exp_w[i]);
        end
        send(1'b0, 2'h3, 3'h6, 4'h0, 3'h0, 2'h3, 64'h0, 1'b0, exp_w[0]);
        @(negedge clock_i);
        @(negedge clock_i);
        check(64'(rsp_q.size()), 64'h0);
        report_and_stop();
    end
endmodule : cache_tlb_debug_readout_tb

// ===== hw/cache_tlb_debug_readout.sv
// system-register readout of the l1 cache and tlb rams
`include "readout_consts.svh"
module cache_tlb_debug_readout
    import readout_pkg::*;
#(
    parameter bit LARGE_DCACHE = 1'b0
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // system register access
    input  wire sysreg_req_t req_i,
    output logic             req_ready_o,
    output sysreg_rsp_t      rsp_o,
    // internal ram read port
    output ram_req_t         ram_req_o,
    input  wire ram_rsp_t    ram_rsp_i
);
    typedef enum logic [2:0] {ST_IDLE, ST_RAM, ST_STORE, ST_READ} state_t;

    localparam int SET_TOP = LARGE_DCACHE ? `S_64K : `S_32K; // see RULE9
    localparam logic [8:0] SET_MASK = 9'((1 << (SET_TOP - `SET_LO)) - 1);

    function automatic ram_target_t to_target(logic [3:0] crm, logic [2:0] op2);
        ram_target_t t;
        t = TGT_DC_TAG;
        case ({crm == `CRM_DAT, op2})
            {1'b0, `OP2_DC}:  t = TGT_DC_TAG;
            {1'b0, `OP2_IC}:  t = TGT_IC_TAG;
            {1'b0, `OP2_TLB}: t = TGT_TLB_TAG;
            {1'b1, `OP2_DC}:  t = TGT_DC_DATA;
            {1'b1, `OP2_IC}:  t = TGT_IC_DATA;
            {1'b1, `OP2_TLB}: t = TGT_TLB_DATA;
            default:          t = TGT_DC_TAG;
        endcase
        return t;
    endfunction : to_target

    // bits 14:S of the selection word are dropped by the mask
    function automatic logic [8:0] set_field(logic [63:0] d);
        return d[`SET_LO+8:`SET_LO] & SET_MASK;
    endfunction : set_field

    function automatic logic [63:0] format_word(ram_target_t t, logic [1:0] i,
                                                logic [88:0] r);
        dc_tag_raw_t tg;
        logic [63:0] w;
        tg = dc_tag_raw_t'(r[7:0]);
        w  = '0;
        case (t)
            TGT_DC_TAG: begin
                if (i == `RES_W0) begin
                    w[`W0_DIRTY]               = tg.dirty; // see RULE14
                    w[`W0_SHARE]               = tg.share;
                    w[`W0_AGE_LO+1:`W0_AGE_LO] = tg.age;
                    w[`W0_HINT]                = tg.hint;
                end else if (i == `RES_W1) begin
                    w[`W1_STATE_LO+1:`W1_STATE_LO] = tg.state;           // see RULE12
                    w[`W1_NONSEC]                  = tg.non_secure_flag; // see RULE13
                end
            end
            TGT_DC_DATA, TGT_IC_TAG: begin
                // low word then high word of the 64-bit entry
                if (i == `RES_W0) begin
                    w[`WORD_W-1:0] = r[`WORD_W-1:0]; // see RULE15
                end else if (i == `RES_W1) begin
                    w[`WORD_W-1:0] = r[2*`WORD_W-1:`WORD_W];
                end
            end
            TGT_IC_DATA: begin
                if (i == `RES_W0) begin
                    w[`PD_W-1:0] = r[`PD_W-1:0]; // see RULE18
                end else if (i == `RES_W1) begin
                    w[`PD_W-1:0] = r[2*`PD_W-1:`PD_W];
                end
            end
            TGT_TLB_TAG, TGT_TLB_DATA: begin
                if (i == `RES_W0) begin
                    w[`WORD_W-1:0] = r[`WORD_W-1:0];
                end else if (i == `RES_W1) begin
                    w[`WORD_W-1:0] = r[2*`WORD_W-1:`WORD_W];
                end else if (i == `RES_W2) begin
                    w[`TLB_TOP-2*`WORD_W:0] = r[`TLB_TOP:2*`WORD_W];
                end
            end
            default: w = '0;
        endcase
        return w;
    endfunction : format_word

    state_t      state_q, state_d;
    ram_target_t tgt_q, tgt_d;
    logic [88:0] raw_q, raw_d;
    logic [1:0]  cnt_q, cnt_d;
    ram_req_t    ram_req_d;
    sysreg_rsp_t rsp_d;
    logic        ready_d;

    // request decode
    wire logic [63:0] wd      = req_i.wdata;
    wire sysreg_enc_t enc     = req_i.enc;
    wire logic        take    = req_i.valid && req_ready_o;
    wire logic        el_ok   = req_i.el == `EL_TOP; // see RULE1
    wire logic        is_imp  = enc.op1 == `OP1_IMP && enc.crn == `CRN_IMP;
    wire logic        op2_ok  = enc.op2 <= `OP2_TLB;
    wire logic        is_rd   = is_imp && op2_ok && !req_i.write && enc.op0 == `OP0_RD
                                && enc.crm == `CRM_RES; // see RULE3
    wire logic        is_wr   = is_imp && op2_ok && req_i.write && enc.op0 == `OP0_WR
                                && (enc.crm == `CRM_TAG || enc.crm == `CRM_DAT); // see RULE2
    wire logic        do_rd   = take && el_ok && is_rd;
    wire logic        do_wr   = take && el_ok && is_wr;
    // wrong direction, unknown encoding or low level all trap
    wire logic        do_bad  = take && !(el_ok && (is_rd || is_wr)); // see RULE1
    wire ram_target_t tgt_new = to_target(enc.crm, enc.op2);

    // location decode
    wire logic [1:0]  sel_way = wd[`WAY_HI:`WAY_LO]; // see RULE8
    wire logic [8:0]  tlb_idx = wd[`TIDX_HI:0];      // see RULE17
    wire logic        is_tlb  = tgt_new == TGT_TLB_TAG || tgt_new == TGT_TLB_DATA;
    wire logic        tlb_oor = is_tlb && tlb_idx > `TLB_END;
    wire tlb_part_t   part    = tlb_idx >= `TLB_IPA  ? PART_IPA :
                                tlb_idx >= `TLB_WALK ? PART_WALK : PART_MAIN;
    wire logic [8:0]  sel_idx = is_tlb ? tlb_idx : set_field(wd); // see RULE10
    wire logic [3:0]  sel_off = tgt_new == TGT_DC_DATA ?
                                {1'b0, wd[`DOFF_HI:`DOFF_LO]} : // see RULE5
                                tgt_new == TGT_IC_DATA ?
                                wd[`IOFF_HI:`IOFF_LO] : 4'h0;   // see RULE16

    // result store access
    wire logic        st_wr   = state_q == ST_STORE;
    wire logic [63:0] st_data = format_word(tgt_q, cnt_q, raw_q); // see RULE11
    wire logic [63:0] st_rd;

    result_store result_store_i (
        .clock_i   (clock_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (st_wr),
        .wr_idx_i  (cnt_q),
        .wr_data_i (st_data),
        .rd_idx_i  (enc.op2[1:0]),
        .rd_data_o (st_rd)
    );

    always_comb begin
        state_d   = state_q;
        tgt_d     = tgt_q;
        raw_d     = raw_q;
        cnt_d     = cnt_q;
        ram_req_d = '0;
        rsp_d     = '0;
        case (state_q)
            ST_IDLE: begin
                if (do_bad) begin
                    rsp_d.valid = 1'b1;
                    rsp_d.undef = 1'b1; // see RULE1
                end else if (do_rd) begin
                    state_d = ST_READ;
                end else if (do_wr) begin
                    tgt_d = tgt_new;
                    cnt_d = `RES_W0;
                    if (tlb_oor) begin
                        // no entry there: publish all-zero results
                        raw_d   = '0; // see RULE20
                        state_d = ST_STORE;
                    end else begin
                        ram_req_d.valid  = 1'b1; // see RULE4
                        ram_req_d.target = tgt_new; // see RULE6
                        ram_req_d.part   = part;    // see RULE7
                        ram_req_d.way    = sel_way;
                        ram_req_d.index  = sel_idx;
                        ram_req_d.offset = sel_off;
                        state_d          = ST_RAM;
                    end
                end
            end
            ST_RAM: begin
                if (ram_rsp_i.valid) begin
                    raw_d   = ram_rsp_i.data;
                    state_d = ST_STORE;
                end
            end
            ST_STORE: begin
                // all three words are rewritten so stale bits cannot leak
                cnt_d = cnt_q + 2'h1; // see RULE20
                if (cnt_q == `RES_W2) begin
                    cnt_d       = `RES_W0;
                    rsp_d.valid = 1'b1; // see RULE19
                    state_d     = ST_IDLE;
                end
            end
            ST_READ: begin
                rsp_d.valid = 1'b1;
                rsp_d.rdata = st_rd; // see RULE3
                state_d     = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    assign ready_d = state_d == ST_IDLE;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
            tgt_q   <= TGT_DC_TAG;
            cnt_q   <= `RES_W0;
        end else begin
            state_q <= state_d;
            tgt_q   <= tgt_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            raw_q       <= '0;
            ram_req_o   <= '0;
            rsp_o       <= '0;
            req_ready_o <= 1'b0;
        end else begin
            raw_q       <= raw_d;
            ram_req_o   <= ram_req_d;
            rsp_o       <= rsp_d;
            req_ready_o <= ready_d;
        end
    end

    // checks
    low_el_trap_a: assert property ( // see RULE1
        @(posedge clock_i) disable iff (!rst_b_i)
        take && req_i.el != `EL_TOP |=> rsp_o.valid && rsp_o.undef && !ram_req_o.valid)
        else $error("access below top level did not trap");

    wrong_dir_a: assert property ( // see RULE2
        @(posedge clock_i) disable iff (!rst_b_i)
        take && el_ok && is_imp && !is_rd && !is_wr |=> rsp_o.undef)
        else $error("wrong-direction access did not trap");

    result_read_a: assert property ( // see RULE3
        @(posedge clock_i) disable iff (!rst_b_i)
        do_rd |=> !rsp_o.valid ##1 (rsp_o.valid && !rsp_o.undef))
        else $error("result read not answered in two cycles");

    ram_issue_a: assert property ( // see RULE4
        @(posedge clock_i) disable iff (!rst_b_i)
        do_wr && !tlb_oor |=> ram_req_o.valid && ram_req_o.target == $past(tgt_new))
        else $error("operation write did not start a ram read");

    dc_select_a: assert property ( // see RULE10
        @(posedge clock_i) disable iff (!rst_b_i)
        do_wr && tgt_new == TGT_DC_DATA |=> ram_req_o.way == $past(wd[`WAY_HI:`WAY_LO])
        && ram_req_o.offset[2:0] == $past(wd[`DOFF_HI:`DOFF_LO])
        && ram_req_o.index == ($past(wd[`SET_LO+8:`SET_LO]) & SET_MASK))
        else $error("data cache selection decoded wrongly");

    tlb_part_a: assert property ( // see RULE17
        @(posedge clock_i) disable iff (!rst_b_i)
        do_wr && is_tlb && tlb_idx >= `TLB_WALK && tlb_idx < `TLB_IPA
        |=> ram_req_o.part == PART_WALK)
        else $error("walk cache index not steered");

    tag_state_a: assert property ( // see RULE12
        @(posedge clock_i) disable iff (!rst_b_i)
        st_wr && tgt_q == TGT_DC_TAG && cnt_q == `RES_W1
        |-> st_data[`W1_STATE_LO+1:`W1_STATE_LO] == raw_q[1:0] && !st_data[0])
        else $error("coherence state misplaced");

    tag_zero_a: assert property ( // see RULE14
        @(posedge clock_i) disable iff (!rst_b_i)
        st_wr && tgt_q == TGT_DC_TAG && cnt_q == `RES_W0 |-> st_data[63:5] == '0)
        else $error("result_word_0 upper bits not zero");

    predecode_a: assert property ( // see RULE18
        @(posedge clock_i) disable iff (!rst_b_i)
        st_wr && tgt_q == TGT_IC_DATA && cnt_q == `RES_W1
        |-> st_data == {44'h0, raw_q[2*`PD_W-1:`PD_W]})
        else $error("second predecode entry misplaced");

    store_done_a: assert property ( // see RULE19
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(st_wr) |-> st_wr [*3] ##1 (rsp_o.valid && req_ready_o))
        else $error("result store sequence not three words");

    op_busy_a: assert property ( // see RULE19
        @(posedge clock_i) disable iff (!rst_b_i)
        do_wr
        |=> !req_ready_o && !rsp_o.valid)
        else $error("operation write answered before its results");

    // a trap must not touch the results or the idle state
    trap_quiet_a: assert property ( // see RULE1
        @(posedge clock_i) disable iff (!rst_b_i)
        do_bad
        |=> !st_wr && !ram_req_o.valid && req_ready_o)
        else $error("trapped access disturbed the readout");

    oor_zero_a: assert property ( // see RULE20
        @(posedge clock_i) disable iff (!rst_b_i)
        do_wr && tlb_oor
        |=> !ram_req_o.valid && st_wr && raw_q == '0)
        else $error("tlb index past the end not zeroed");

    ic_offset_a: assert property ( // see RULE16
        @(posedge clock_i) disable iff (!rst_b_i)
        do_wr && tgt_new == TGT_IC_DATA
        |=> ram_req_o.offset == $past(wd[`IOFF_HI:`IOFF_LO]))
        else $error("instruction cache offset decoded wrongly");

    tlb_select_a: assert property ( // see RULE17
        @(posedge clock_i) disable iff (!rst_b_i)
        do_wr && is_tlb && !tlb_oor
        |=> ram_req_o.index == $past(wd[`TIDX_HI:0])
        && ram_req_o.way == $past(wd[`WAY_HI:`WAY_LO]))
        else $error("tlb index or way decoded wrongly");

    // the 64KB build widens the set field by one bit
    set_range_a: assert property ( // see RULE9
        @(posedge clock_i) disable iff (!rst_b_i)
        ram_req_o.valid && !(ram_req_o.target inside {TGT_TLB_TAG, TGT_TLB_DATA})
        |-> (ram_req_o.index >> (SET_TOP - `SET_LO)) == 9'h0)
        else $error("set index above the configured field");

    // result format checks
    data_split_a: assert property ( // see RULE15
        @(posedge clock_i) disable iff (!rst_b_i)
        st_wr && tgt_q == TGT_DC_DATA && cnt_q == `RES_W1
        |-> st_data == {32'h0, raw_q[2*`WORD_W-1:`WORD_W]})
        else $error("upper data word misplaced");

    tlb_word2_a: assert property ( // see RULE17
        @(posedge clock_i) disable iff (!rst_b_i)
        st_wr && tgt_q inside {TGT_TLB_TAG, TGT_TLB_DATA} && cnt_q == `RES_W2
        |-> st_data == {39'h0, raw_q[`TLB_TOP:2*`WORD_W]})
        else $error("tlb descriptor top misplaced");

    spare_word_a: assert property ( // see RULE20
        @(posedge clock_i) disable iff (!rst_b_i)
        st_wr && cnt_q == `RES_W2 && !(tgt_q inside {TGT_TLB_TAG, TGT_TLB_DATA})
        |-> st_data == '0)
        else $error("unused result word not zero");

    cover_trap_c:  cover property (@(posedge clock_i) disable iff (!rst_b_i) rsp_o.undef);
    cover_dctag_c: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        ram_req_o.valid && ram_req_o.target == TGT_DC_TAG);
    cover_oor_c:   cover property (@(posedge clock_i) disable iff (!rst_b_i) do_wr && tlb_oor);
    cover_read_c:  cover property (@(posedge clock_i) disable iff (!rst_b_i) do_rd);
    cover_icdata_c: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        ram_req_o.valid && ram_req_o.target == TGT_IC_DATA);
endmodule : cache_tlb_debug_readout

// ===== hw/readout_consts.svh
// constants for the cache and tlb readout path
// What this block does
// RULE1: readout registers work only at the top exception level, else undefined.
// RULE2: write-only select registers pick a location; read-only result registers return it.
// RULE3: three result registers read at op1 6, CRn 15, CRm 0, op2 0-2.
// RULE4: writing dcache_tag_select reads the data cache tag at set and way.
// RULE5: writing dcache_data_select reads data cache data at set, way, offset.
// RULE6: icache tag and data select registers; data one also takes an offset.
// RULE7: tlb tag and data select registers pick an entry by index and way.
// RULE8: the level-one data cache has four ways.
// RULE9: set field top bound is 13 for 32KB, 14 for 64KB.
// RULE10: data cache way 31:30, set S-1:6, offset 5:3; other bits ignored.
// RULE11: data cache tag read returns state, attributes, validity in words 0 and 1.
// RULE12: result_word_1 bits 31:30 hold coherence state, 00 invalid to 11 transient.
// RULE13: result_word_1 bit 29 holds non_secure_flag; bit 0 reads zero.
// RULE14: result_word_0 holds dirty 4, share 3, age 2:1, hint 0, zero above.
// RULE15: data cache data read returns 64 bits across result words 0 and 1.
// RULE16: instruction cache readout uses its own selection and result format.
// RULE17: tlb way 31:30, index 8:0 picks main tlb, walk or ipa cache.
// RULE18: icache data read returns two 20-bit predecode entries in words 0, 1.
// RULE19: results hold the last operation outcome until the next operation write.
// RULE20: result bits the operation does not define read as zero.
`ifndef READOUT_CONSTS_SVH
`define READOUT_CONSTS_SVH
`define EL_TOP       2'h3
`define OP0_RD       2'h3
`define OP0_WR       2'h1
`define OP1_IMP      3'h6
`define CRN_IMP      4'hf
`define CRM_RES      4'h0
`define CRM_TAG      4'h2
`define CRM_DAT      4'h4
`define OP2_DC       3'h0
`define OP2_IC       3'h1
`define OP2_TLB      3'h2
`define WAY_HI       31
`define WAY_LO       30
`define SET_LO       6
`define S_32K        13
`define S_64K        14
`define DOFF_HI      5
`define DOFF_LO      3
`define IOFF_HI      5
`define IOFF_LO      2
`define TIDX_HI      8
`define TLB_WALK     9'h100
`define TLB_IPA      9'h110
`define TLB_END      9'h11f
`define WORD_W       32
`define PD_W         20
`define TLB_TOP      88
`define W1_STATE_LO  30
`define W1_NONSEC    29
`define W0_DIRTY     4
`define W0_SHARE     3
`define W0_AGE_LO    1
`define W0_HINT      0
`define RES_W0       2'h0
`define RES_W1       2'h1
`define RES_W2       2'h2
`endif

// ===== hw/readout_pkg.sv
// types shared by the readout path
package readout_pkg;
    typedef struct packed {
        logic [1:0] op0;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
    } sysreg_enc_t;
    typedef struct packed {
        logic        valid;
        logic        write;
        sysreg_enc_t enc;
        logic [1:0]  el;
        logic [63:0] wdata;
    } sysreg_req_t;
    typedef struct packed {
        logic        valid;
        logic        undef;
        logic [63:0] rdata;
    } sysreg_rsp_t;
    typedef enum logic [2:0] {
        TGT_DC_TAG, TGT_DC_DATA, TGT_IC_TAG, TGT_IC_DATA, TGT_TLB_TAG, TGT_TLB_DATA
    } ram_target_t;
    typedef enum logic [1:0] {PART_MAIN, PART_WALK, PART_IPA} tlb_part_t;
    typedef struct packed {
        logic        valid;
        ram_target_t target;
        tlb_part_t   part;
        logic [1:0]  way;
        logic [8:0]  index;
        logic [3:0]  offset;
    } ram_req_t;
    typedef struct packed {
        logic        valid;
        logic [88:0] data;
    } ram_rsp_t;
    typedef struct packed {
        logic       hint;
        logic [1:0] age;
        logic       share;
        logic       dirty;
        logic       non_secure_flag;
        logic [1:0] state;
    } dc_tag_raw_t;
endpackage : readout_pkg

// ===== hw/result_store.sv
// three-word result store with registered read data
`include "readout_consts.svh"
module result_store (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // write port
    input  wire logic        wr_en_i,
    input  wire logic [1:0]  wr_idx_i,
    input  wire logic [63:0] wr_data_i,
    // read port
    input  wire logic [1:0]  rd_idx_i,
    output logic      [63:0] rd_data_o
);
    logic [63:0] mem_q [3];

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            mem_q[2] <= '0;
        end else if (wr_en_i && wr_idx_i <= `RES_W2) begin
            mem_q[wr_idx_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= (rd_idx_i <= `RES_W2) ? mem_q[rd_idx_i] : '0;
        end
    end
endmodule : result_store
